//--- rtl/msc_pkg.sv
// Constants and types for the modem serial control block
`default_nettype none
package msc_pkg;
  localparam int unsigned CTRL_W        = 16;
  localparam int unsigned STATUS_W      = 4;
  localparam int unsigned FN_LSB        = 0;
  localparam int unsigned ATT_LSB       = 4;
  localparam int unsigned TONE_LSB      = 8;
  localparam int unsigned MUTE_BIT      = 12;
  localparam int unsigned CHAN_BIT      = 13;
  localparam int unsigned DT_LO_BIT     = 14;
  localparam int unsigned DT_HI_BIT     = 15;
  localparam bit          SHIFT_LSB_FIRST = 1'b1;

  localparam logic [3:0] FN_FSK     = 4'h0;
  localparam logic [3:0] FN_FSK_LB  = 4'h1;
  localparam logic [3:0] FN_CPTD    = 4'h2;
  localparam logic [3:0] FN_ANSWER  = 4'h3;
  localparam logic [3:0] FN_DTMF_TX = 4'h4;
  localparam logic [3:0] FN_SINGLE  = 4'h5;
  localparam logic [3:0] FN_PD1     = 4'h6;
  localparam logic [3:0] FN_PD2     = 4'h7;
  localparam logic [3:0] FN_DTMF_RX = 4'h8;
  localparam logic [3:0] FN_DTMF_LB = 4'h9;

  // Deepest power-down, everything else zero
  localparam logic [15:0] CTRL_RST  = 16'h0007;

  localparam logic [10:0] F_697  = 11'h2b9;
  localparam logic [10:0] F_770  = 11'h302;
  localparam logic [10:0] F_852  = 11'h354;
  localparam logic [10:0] F_941  = 11'h3ad;
  localparam logic [10:0] F_1209 = 11'h4b9;
  localparam logic [10:0] F_1336 = 11'h538;
  localparam logic [10:0] F_1477 = 11'h5c5;
  localparam logic [10:0] F_1633 = 11'h661;
  localparam logic [10:0] F_NONE = 11'h000;

  // Qualification times in ms
  localparam logic [8:0] FSK_ON_0  = 9'h1c2;
  localparam logic [8:0] FSK_ON_1  = 9'h00a;
  localparam logic [8:0] FSK_ON_2  = 9'h00a;
  localparam logic [8:0] FSK_ON_3  = 9'h046;
  localparam logic [8:0] FSK_OFF_0 = 9'h023;
  localparam logic [8:0] FSK_OFF_1 = 9'h023;
  localparam logic [8:0] FSK_OFF_2 = 9'h014;
  localparam logic [8:0] FSK_OFF_3 = 9'h00f;
  localparam logic [8:0] DT_ON_1   = 9'h019;
  localparam logic [8:0] DT_ON_2   = 9'h01e;
  localparam logic [8:0] DT_ON_3   = 9'h028;
  localparam logic [8:0] DT_OFF_1  = 9'h019;
  localparam logic [8:0] DT_OFF_2  = 9'h023;
  localparam logic [8:0] DT_OFF_3  = 9'h019;
  localparam logic [8:0] QUAL_NONE = 9'h000;

  typedef enum logic [2:0] {
    TXS_MID, TXS_FSK, TXS_ANSWER, TXS_DTMF, TXS_SINGLE
  } msc_txsrc_type;
endpackage
`default_nettype wire

//--- rtl/msc_serial_ctrl.sv
// Serial control and status registers of the modem, with mode decode
`default_nettype none
module msc_serial_ctrl
  import msc_pkg::*;
(
  // System clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Serial link from the host
  input  wire logic          sck_clk,
  input  wire logic          strobe_e,
  input  wire logic          dir_read,
  input  wire logic          data_in,
  output var  logic          data_out,
  output var  logic          data_oe_n,
  // DTMF decoder result
  input  wire logic [3:0]    rx_tone_code,
  // Transmit path control
  output var  msc_txsrc_type tx_src,
  output var  logic [10:0]   tx_low_hz,
  output var  logic [10:0]   tx_high_hz,
  output var  logic [3:0]    tx_atten,
  output var  logic          ext_tx_pass,
  output var  logic          line_out_oe_n,
  // Receive path control
  output var  logic          chan_originate,
  output var  logic [8:0]    qual_on_ms,
  output var  logic [8:0]    qual_off_ms,
  output var  logic          detect_time_reserved,
  output var  logic [10:0]   rx_low_hz,
  output var  logic [10:0]   rx_high_hz,
  // Power and pin enables
  output var  logic          osc_en,
  output var  logic          rx_pins_oe_n
);
  // ---------------- Link clock domain ----------------
  logic        sck_rst;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [1:0]  rd_bin_q;
  logic [1:0]  rd_bin_d;
  logic [1:0]  rd_gray_q;

  // Reset only takes effect once the host clock runs
  msc_sync2 #(.W(1)) u_sck_rst (
    .clk (sck_clk),
    .rst (1'b0),
    .d   (sys_rst),
    .q   (sck_rst)
  );

  assign shift_d = SHIFT_LSB_FIRST ? {data_in, shift_q[15:1]}
                                   : {shift_q[14:0], data_in};
  assign rd_bin_d = rd_bin_q + 2'h1;

  always_ff @(posedge sck_clk) begin
    if (sck_rst) begin
      shift_q   <= 16'h0000;
      rd_bin_q  <= 2'h0;
      rd_gray_q <= 2'h0;
    end else if (!dir_read) begin
      shift_q   <= shift_d;
    end else begin
      rd_bin_q  <= rd_bin_d;
      rd_gray_q <= rd_bin_d ^ {1'b0, rd_bin_d[1]};
    end
  end

  // ---------------- System clock domain ----------------
  logic       strobe_s;
  logic       dir_s;
  logic [1:0] gray_s;
  logic       strobe_prev_q;
  logic       e_rise;
  logic       load_ctrl;
  logic       load_stat;
  logic [1:0] bin_s;
  logic [1:0] base_q;
  logic [1:0] idx;
  logic       reading_q;
  logic       data_out_d;
  logic [15:0] ctrl_q;
  logic [3:0]  status_q;

  msc_sync2 #(.W(1)) u_strobe (
    .clk (clk),
    .rst (sys_rst),
    .d   (strobe_e),
    .q   (strobe_s)
  );

  msc_sync2 #(.W(1)) u_dir (
    .clk (clk),
    .rst (sys_rst),
    .d   (dir_read),
    .q   (dir_s)
  );

  // Gray count changes one bit per edge, so two flops suffice
  msc_sync2 #(.W(2)) u_gray (
    .clk (clk),
    .rst (sys_rst),
    .d   (rd_gray_q),
    .q   (gray_s)
  );

  assign e_rise    = strobe_s & ~strobe_prev_q;
  assign load_ctrl = e_rise & ~dir_s;
  assign load_stat = e_rise & dir_s;
  assign bin_s     = {gray_s[1], gray_s[1] ^ gray_s[0]};
  assign idx       = bin_s - base_q;

  // Status bit order follows serial clock edges since the strobe
  assign data_out_d = load_stat ? rx_tone_code[0]
                                : status_q[idx];

  // Shift word is quasi-static while the strobe is high: the host stops
  // the serial clock first, and the strobe is seen two flops later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strobe_prev_q <= 1'b0;
      ctrl_q        <= CTRL_RST;
      status_q      <= 4'h0;
      base_q        <= 2'h0;
      reading_q     <= 1'b0;
      data_out      <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_s;
      if (load_ctrl) begin
        ctrl_q <= shift_q;
      end
      if (load_stat) begin
        status_q <= rx_tone_code;
        base_q   <= bin_s;
      end
      reading_q <= dir_s & (reading_q | load_stat);
      data_out  <= data_out_d;
    end
  end

  // ---------------- Mode decode ----------------
  logic [3:0]    fn;
  logic [3:0]    tone_code;
  logic [1:0]    dt;
  logic          mute;
  logic          pd;
  logic          pd2;
  logic          fsk_mode;
  logic          dtmf_rx_mode;
  logic [10:0]   rom_low;
  logic [10:0]   rom_high;
  logic [10:0]   rom_single;
  logic [10:0]   rx_low_w;
  logic [10:0]   rx_high_w;
  msc_txsrc_type src_mode;
  msc_txsrc_type src_d;
  logic [10:0]   low_d;
  logic [10:0]   high_d;
  logic [8:0]    on_d;
  logic [8:0]    off_d;

  assign fn        = ctrl_q[FN_LSB +: 4];
  assign tone_code = ctrl_q[TONE_LSB +: 4];
  assign dt        = {ctrl_q[DT_HI_BIT], ctrl_q[DT_LO_BIT]};
  assign mute      = ctrl_q[MUTE_BIT];
  assign pd        = (fn == FN_PD1) | (fn == FN_PD2);
  assign pd2       = (fn == FN_PD2);
  assign fsk_mode  = (fn == FN_FSK) | (fn == FN_FSK_LB);
  assign dtmf_rx_mode = (fn == FN_DTMF_RX) | (fn == FN_DTMF_LB);

  msc_tone_rom u_tx_rom (
    .code      (tone_code),
    .low_hz    (rom_low),
    .high_hz   (rom_high),
    .single_hz (rom_single)
  );

  // Same table decodes the captured status code
  msc_tone_rom u_rx_rom (
    .code      (status_q),
    .low_hz    (rx_low_w),
    .high_hz   (rx_high_w),
    .single_hz ()
  );

  always_comb begin
    unique case (fn)
      FN_FSK, FN_FSK_LB:     src_mode = TXS_FSK;
      FN_ANSWER:             src_mode = TXS_ANSWER;
      FN_DTMF_TX, FN_DTMF_LB: src_mode = TXS_DTMF;
      FN_SINGLE:             src_mode = TXS_SINGLE;
      default:               src_mode = TXS_MID;
    endcase
  end

  // Mute clamps every generated source; external input is separate
  assign src_d  = mute ? TXS_MID : src_mode;
  assign low_d  = (src_d == TXS_DTMF)   ? rom_low
                : (src_d == TXS_SINGLE) ? rom_single : F_NONE;
  assign high_d = (src_d == TXS_DTMF)   ? rom_high : F_NONE;

  always_comb begin
    on_d  = QUAL_NONE;
    off_d = QUAL_NONE;
    if (fsk_mode) begin
      unique case (dt)
        2'h0: begin on_d = FSK_ON_0; off_d = FSK_OFF_0; end
        2'h1: begin on_d = FSK_ON_1; off_d = FSK_OFF_1; end
        2'h2: begin on_d = FSK_ON_2; off_d = FSK_OFF_2; end
        2'h3: begin on_d = FSK_ON_3; off_d = FSK_OFF_3; end
      endcase
    end else if (dtmf_rx_mode) begin
      unique case (dt)
        2'h0: begin on_d = QUAL_NONE; off_d = QUAL_NONE; end
        2'h1: begin on_d = DT_ON_1; off_d = DT_OFF_1; end
        2'h2: begin on_d = DT_ON_2; off_d = DT_OFF_2; end
        2'h3: begin on_d = DT_ON_3; off_d = DT_OFF_3; end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_src               <= TXS_MID;
      tx_low_hz            <= F_NONE;
      tx_high_hz           <= F_NONE;
      tx_atten             <= 4'h0;
      ext_tx_pass          <= 1'b0;
      line_out_oe_n        <= 1'b1;
      chan_originate       <= 1'b0;
      qual_on_ms           <= QUAL_NONE;
      qual_off_ms          <= QUAL_NONE;
      detect_time_reserved <= 1'b0;
      rx_low_hz            <= F_NONE;
      rx_high_hz           <= F_NONE;
      osc_en               <= 1'b0;
      rx_pins_oe_n         <= 1'b1;
      data_oe_n            <= 1'b1;
    end else begin
      tx_src               <= src_d;
      tx_low_hz            <= low_d;
      tx_high_hz           <= high_d;
      tx_atten             <= ctrl_q[ATT_LSB +: 4];
      ext_tx_pass          <= ~pd;
      line_out_oe_n        <= pd;
      chan_originate       <= fsk_mode & ctrl_q[CHAN_BIT];
      qual_on_ms           <= on_d;
      qual_off_ms          <= off_d;
      detect_time_reserved <= dtmf_rx_mode & (dt == 2'h0);
      rx_low_hz            <= rx_low_w;
      rx_high_hz           <= rx_high_w;
      osc_en               <= ~pd2;
      rx_pins_oe_n         <= pd;
      data_oe_n            <= ~(dir_s & (reading_q | load_stat));
    end
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_word_taken;
    load_ctrl ##1 (ctrl_q == $past(shift_q));
  endsequence

  property p_reset_pd2;
    @(posedge clk) disable iff (1'b0)
      sys_rst |=> (fn == FN_PD2) && !osc_en && line_out_oe_n;
  endproperty
  a_reset_pd2: assert property (p_reset_pd2)
    else $error("reset did not enter deepest power-down");

  property p_ctrl_load;
    load_ctrl |=> (ctrl_q == $past(shift_q));
  endproperty
  a_ctrl_load: assert property (p_ctrl_load)
    else $error("control word not applied on strobe rise");

  property p_ctrl_hold;
    !load_ctrl |=> $stable(ctrl_q);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control word changed without strobe");

  property p_status_first;
    load_stat |=> (status_q == $past(rx_tone_code))
                  && (data_out == $past(rx_tone_code[0])) && !data_oe_n;
  endproperty
  a_status_first: assert property (p_status_first)
    else $error("status bit 0 not presented at strobe rise");

  property p_status_next;
    reading_q && dir_s && !load_stat && $changed(gray_s)
      |=> data_out == status_q[$past(idx)] && idx == $past(idx);
  endproperty
  a_status_next: assert property (p_status_next)
    else $error("status bit rotation wrong");

  property p_mute;
    s_word_taken ##0 mute |=> (tx_src == TXS_MID) && (tx_low_hz == F_NONE);
  endproperty
  a_mute: assert property (p_mute)
    else $error("muted transmit still carries a tone");

  property p_ext_pass;
    mute && !pd |=> ext_tx_pass;
  endproperty
  a_ext_pass: assert property (p_ext_pass)
    else $error("mute blocked the external transmit path");

  property p_dtmf_d;
    (src_d == TXS_DTMF) && (tone_code == 4'h0)
      |=> (tx_low_hz == F_941) && (tx_high_hz == F_1633);
  endproperty
  a_dtmf_d: assert property (p_dtmf_d)
    else $error("tone code 0 pair wrong");

  property p_chan;
    fsk_mode |=> chan_originate == $past(ctrl_q[CHAN_BIT]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel select wrong in FSK mode");

  property p_fsk_qual;
    fsk_mode && (dt == 2'h0) |=> (qual_on_ms == FSK_ON_0)
                                && (qual_off_ms == FSK_OFF_0);
  endproperty
  a_fsk_qual: assert property (p_fsk_qual)
    else $error("FSK qualification time wrong");

  property p_dt_reserved;
    dtmf_rx_mode && (dt == 2'h0) |=> detect_time_reserved
                                    && (qual_on_ms == QUAL_NONE);
  endproperty
  a_dt_reserved: assert property (p_dt_reserved)
    else $error("reserved detect time not flagged");

  property p_pd_hiz;
    pd |=> line_out_oe_n && rx_pins_oe_n && !ext_tx_pass;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz)
    else $error("power-down left a line output enabled");
endmodule
`default_nettype wire

//--- rtl/msc_sync2.sv
// Two-flop level synchroniser
`default_nettype none
module msc_sync2 #(
  parameter int unsigned W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Level in and out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First flop feeds only the second one
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- rtl/msc_tone_rom.sv
// Keypad code to tone frequency table
`default_nettype none
module msc_tone_rom
  import msc_pkg::*;
(
  // Code in
  input  wire logic [3:0]  code,
  // Frequencies out in Hz
  output var  logic [10:0] low_hz,
  output var  logic [10:0] high_hz,
  output var  logic [10:0] single_hz
);
  always_comb begin
    unique case (code)
      4'h0: begin low_hz = F_941; high_hz = F_1633; end
      4'h1: begin low_hz = F_697; high_hz = F_1209; end
      4'h2: begin low_hz = F_697; high_hz = F_1336; end
      4'h3: begin low_hz = F_697; high_hz = F_1477; end
      4'h4: begin low_hz = F_770; high_hz = F_1209; end
      4'h5: begin low_hz = F_770; high_hz = F_1336; end
      4'h6: begin low_hz = F_770; high_hz = F_1477; end
      4'h7: begin low_hz = F_852; high_hz = F_1209; end
      4'h8: begin low_hz = F_852; high_hz = F_1336; end
      4'h9: begin low_hz = F_852; high_hz = F_1477; end
      4'ha: begin low_hz = F_941; high_hz = F_1336; end
      4'hb: begin low_hz = F_941; high_hz = F_1209; end
      4'hc: begin low_hz = F_941; high_hz = F_1477; end
      4'hd: begin low_hz = F_697; high_hz = F_1633; end
      4'he: begin low_hz = F_770; high_hz = F_1633; end
      4'hf: begin low_hz = F_852; high_hz = F_1633; end
    endcase
  end

  // Lower half plays its low tone alone, upper half its high tone
  assign single_hz = code[3] ? high_hz : low_hz;
endmodule
`default_nettype wire

//--- verification/msc_host_model.sv
// Host model that drives the serial control link of the modem
`default_nettype none
module msc_host_model
  import msc_pkg::*;
(
  // Reference clock for strobe timing
  input  wire logic clk,
  // Serial link towards the device
  output var  logic sck_clk,
  output var  logic strobe_e,
  output var  logic dir_read,
  output var  logic host_d,
  // Resolved data line
  input  wire logic data_line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck_clk  = 1'b0;
    strobe_e = 1'b0;
    dir_read = 1'b0;
    host_d   = 1'b0;
  end

  // One link clock period of 125 ns; the clock idles low between frames
  task automatic sck_pulse();
    #62.5 sck_clk = 1'b1;
    #62.5 sck_clk = 1'b0;
  endtask

  // A few link clocks so the link side sees the system reset
  task automatic idle_clocks();
    dir_read = 1'b0;
    repeat (4) sck_pulse();
  endtask

  // Sixteen bits, one per rising link clock, lsb first
  task automatic shift_word(input logic [CTRL_W-1:0] w);
    int i;
    dir_read = 1'b0;
    for (i = 0; i < CTRL_W; i++) begin
      host_d = SHIFT_LSB_FIRST ? w[i] : w[CTRL_W-1-i];
      sck_pulse();
    end
  endtask

  // Strobe applies the word; link clock stays idle while it is high
  task automatic pulse_strobe();
    @(negedge clk) strobe_e = 1'b1;
    repeat (4) @(negedge clk);
    strobe_e = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Read strobe, then sample the first status bit
  task automatic start_read(output logic b0);
    @(negedge clk) dir_read = 1'b1;
    repeat (4) @(negedge clk);
    strobe_e = 1'b1;
    repeat (5) @(negedge clk);
    b0 = data_line;
    strobe_e = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Seven more bits, each sampled late in the high phase
  task automatic read_bits(output logic [6:0] bits);
    int k;
    for (k = 0; k < 7; k++) begin
      #62.5 sck_clk = 1'b1;
      #62.5 bits[k] = data_line;
      sck_clk = 1'b0;
    end
  endtask

  task automatic end_read();
    @(negedge clk) dir_read = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the modem serial control block
`default_nettype none
module tb_top
  import msc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [15:0]   w;
    msc_txsrc_type src;
    logic [10:0]   lo;
    logic [10:0]   hi;
    logic          ch;
    logic [8:0]    qon;
    logic [8:0]    qoff;
    logic          rsv;
    bit            full;
  } msc_row_type;

  logic          clk, sys_rst, sck_clk, strobe_e, dir_read, host_d;
  logic          data_line, data_out, data_oe_n, ext_tx_pass;
  logic          line_out_oe_n, chan_originate, detect_time_reserved;
  logic          osc_en, rx_pins_oe_n;
  logic [3:0]    rx_tone_code, tx_atten;
  msc_txsrc_type tx_src;
  logic [10:0]   tx_low_hz, tx_high_hz, rx_low_hz, rx_high_hz;
  logic [8:0]    qual_on_ms, qual_off_ms;
  int            n_errors = 0;
  int            n_tests  = 0;
  int            cycles   = 0;
  msc_row_type   rows [$];
  logic [10:0]   lo_t [16] = '{F_941, F_697, F_697, F_697, F_770, F_770,
    F_770, F_852, F_852, F_852, F_941, F_941, F_941, F_697, F_770, F_852};
  logic [10:0]   hi_t [16] = '{F_1633, F_1209, F_1336, F_1477, F_1209,
    F_1336, F_1477, F_1209, F_1336, F_1477, F_1336, F_1209, F_1477,
    F_1633, F_1633, F_1633};

  // The device takes over the line only while its enable is low
  assign data_line = (data_oe_n === 1'b0) ? data_out : host_d;

  msc_host_model host (.clk(clk), .sck_clk(sck_clk), .strobe_e(strobe_e),
    .dir_read(dir_read), .host_d(host_d), .data_line(data_line));

  msc_serial_ctrl dut (.clk(clk), .sys_rst(sys_rst), .sck_clk(sck_clk),
    .strobe_e(strobe_e), .dir_read(dir_read), .data_in(data_line),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .rx_tone_code(rx_tone_code), .tx_src(tx_src), .tx_low_hz(tx_low_hz),
    .tx_high_hz(tx_high_hz), .tx_atten(tx_atten),
    .ext_tx_pass(ext_tx_pass), .line_out_oe_n(line_out_oe_n),
    .chan_originate(chan_originate), .qual_on_ms(qual_on_ms),
    .qual_off_ms(qual_off_ms), .detect_time_reserved(detect_time_reserved),
    .rx_low_hz(rx_low_hz), .rx_high_hz(rx_high_hz), .osc_en(osc_en),
    .rx_pins_oe_n(rx_pins_oe_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run needs about 16000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic ok, input string m);
    n_tests++;
    // An unknown result counts as a failure
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic wr(input logic [15:0] w);
    host.shift_word(w);
    host.pulse_strobe();
  endtask

  // Reset must also see link clocks, so it lasts four link clocks, about 500 ns
  task automatic do_reset();
    @(negedge clk) sys_rst = 1'b1;
    fork
      host.idle_clocks();
      repeat (8) @(negedge clk);
    join
    sys_rst = 1'b0;
    @(negedge clk);
    chk(tx_src === TXS_MID && line_out_oe_n === 1'b1,
        "reset line");
    chk(osc_en === 1'b0 && rx_pins_oe_n === 1'b1, "reset power");
    chk(data_oe_n === 1'b1 && ext_tx_pass === 1'b0, "reset pins");
    // Link side leaves reset only on its own clock edges
    host.idle_clocks();
  endtask

  task automatic check_row(input msc_row_type r);
    logic pd;
    pd = (r.w[3:0] == FN_PD1) || (r.w[3:0] == FN_PD2);
    chk(tx_src === r.src, "transmit source");
    chk(tx_atten === r.w[7:4], "attenuator field");
    chk(chan_originate === r.ch, "channel");
    chk(line_out_oe_n === pd && rx_pins_oe_n === pd, "pins");
    chk(osc_en === (r.w[3:0] != FN_PD2), "oscillator");
    chk(ext_tx_pass === !pd, "external path");
    if (r.full) begin
      chk(tx_low_hz === r.lo && tx_high_hz === r.hi, "tone pair");
      chk(qual_on_ms === r.qon && qual_off_ms === r.qoff,
          "times");
      chk(detect_time_reserved === r.rsv, "reserved time");
    end
  endtask

  initial begin
    logic [3:0]  code;
    logic [10:0] f;
    logic        b0;
    logic [6:0]  bits;
    int          i;
    sys_rst = 1'b1;
    rx_tone_code = 4'h5;
    // Word nibbles: detect time/channel/mute, tone, attenuator, mode
    rows.push_back('{16'h2030, TXS_FSK, F_NONE, F_NONE, 1'b1,
                     FSK_ON_0, FSK_OFF_0, 1'b0, 1'b1});
    rows.push_back('{16'h4050, TXS_FSK, F_NONE, F_NONE, 1'b0,
                     FSK_ON_1, FSK_OFF_1, 1'b0, 1'b1});
    rows.push_back('{16'ha0a0, TXS_FSK, F_NONE, F_NONE, 1'b1,
                     FSK_ON_2, FSK_OFF_2, 1'b0, 1'b1});
    rows.push_back('{16'hc0f0, TXS_FSK, F_NONE, F_NONE, 1'b0,
                     FSK_ON_3, FSK_OFF_3, 1'b0, 1'b1});
    rows.push_back('{16'h3210, TXS_MID, F_NONE, F_NONE, 1'b1,
                     FSK_ON_0, FSK_OFF_0, 1'b0, 1'b1});
    rows.push_back('{16'h6011, TXS_FSK, F_NONE, F_NONE, 1'b1,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b0});
    rows.push_back('{16'h2002, TXS_MID, F_NONE, F_NONE, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b1});
    rows.push_back('{16'h0043, TXS_ANSWER, F_NONE, F_NONE, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b0});
    rows.push_back('{16'h2174, TXS_DTMF, F_697, F_1209, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b1});
    rows.push_back('{16'h1174, TXS_MID, F_NONE, F_NONE, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b0});
    rows.push_back('{16'h0325, TXS_SINGLE, F_NONE, F_NONE, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b0});
    rows.push_back('{16'h0006, TXS_MID, F_NONE, F_NONE, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b1});
    rows.push_back('{16'h0007, TXS_MID, F_NONE, F_NONE, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b1});
    rows.push_back('{16'h60c8, TXS_MID, F_NONE, F_NONE, 1'b0,
                     DT_ON_1, DT_OFF_1, 1'b0, 1'b1});
    rows.push_back('{16'h8008, TXS_MID, F_NONE, F_NONE, 1'b0,
                     DT_ON_2, DT_OFF_2, 1'b0, 1'b1});
    rows.push_back('{16'hc008, TXS_MID, F_NONE, F_NONE, 1'b0,
                     DT_ON_3, DT_OFF_3, 1'b0, 1'b1});
    rows.push_back('{16'h0008, TXS_MID, F_NONE, F_NONE, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b1, 1'b1});
    rows.push_back('{16'h6009, TXS_DTMF, F_941, F_1633, 1'b0,
                     QUAL_NONE, QUAL_NONE, 1'b0, 1'b0});
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].w);
      check_row(rows[i]);
    end
    for (i = 0; i < 16; i++) begin
      code = i[3:0];
      wr({4'h0, code, 4'h0, FN_DTMF_TX});
      chk(tx_low_hz === lo_t[i] && tx_high_hz === hi_t[i],
          "pair");
      wr({4'h0, code, 4'h0, FN_SINGLE});
      f = (i < 8) ? lo_t[i] : hi_t[i];
      chk((tx_low_hz === f && tx_high_hz === F_NONE) ||
          (tx_low_hz === F_NONE && tx_high_hz === f),
          "single tone");
      @(negedge clk) rx_tone_code = code;
      host.start_read(b0);
      chk(b0 === code[0] && data_oe_n === 1'b0, "first bit");
      // Decoder moves on; the status must keep the code taken at the strobe
      @(negedge clk) rx_tone_code = ~code;
      host.read_bits(bits);
      chk(bits === {code, code[3:1]}, "bit rotation");
      chk(rx_low_hz === lo_t[i] && rx_high_hz === hi_t[i],
          "rx pair");
      host.end_read();
      chk(data_oe_n === 1'b1, "line released");
    end
    // Bits shifted without a strobe change nothing; last 16 are kept
    wr(16'h2030);
    host.shift_word(16'h0006);
    repeat (10) @(negedge clk);
    chk(tx_src === TXS_FSK && osc_en === 1'b1, "no strobe");
    host.shift_word(16'h2d09);
    host.pulse_strobe();
    chk(tx_src === TXS_DTMF && tx_low_hz === F_697,
        "last word");
    chk(tx_high_hz === F_1633 && chan_originate === 1'b0,
        "loop");
    do_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
